// File: core/cdbc_pkg.sv
// Function
// - Input mode: capture loads counter value
// - Output mode: read returns active compare value
// - Compare active value with counter continuously
// - Preload off: write acts immediately
// - Preload on: shadow copied at update
// - Four identical compare channels
// - Dead time 0xx: value times one period
// - Dead time 10x: 64 plus low six, step two
// - Dead time 11x: 32 plus low five, step eight/sixteen
// - Level one locks dead time, brake, auto, idle
// - Level two adds polarity and off-state bits
// - Level three adds mode and preload bits
// - Lock level writable once after reset
// - Idle off-state: disabled or inactive then idle
// - Run off-state: disabled or held at inactive level
// - Brake polarity selects brake active level
// - Brake polarity effective one cycle after write
// - Auto enable sets main enable at update
// - Main enable gates primary and complementary outputs
// - Active brake clears main enable asynchronously
// - Output polarity selects primary active level
package cdbc_pkg;

    localparam int unsigned NUM_CHAN = 4;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CMP_W = 16;
    localparam int unsigned DT_W = 11;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CHAN1_CMP_OFF = 8'h34;
    localparam logic [ADDR_W-1:0] CHAN2_CMP_OFF = 8'h38;
    localparam logic [ADDR_W-1:0] CHAN3_CMP_OFF = 8'h3c;
    localparam logic [ADDR_W-1:0] CHAN4_CMP_OFF = 8'h40;
    localparam logic [ADDR_W-1:0] CMP_STRIDE = 8'h04;
    localparam logic [ADDR_W-1:0] BDT_OFF = 8'h44;
    localparam logic [ADDR_W-1:0] CHAN_CONFIG_OFF = 8'h50;
    localparam logic [ADDR_W-1:0] CHAN_OUTCTL_OFF = 8'h54;

    localparam logic [CMP_W-1:0] CMP_RESET = 16'h0000;
    localparam logic [7:0] DTS_RESET = 8'h00;

    // ----------------------------------------------------------------
    // Brake and dead-time fields
    // ----------------------------------------------------------------
    localparam int unsigned DTS_LSB = 0;
    localparam int unsigned DTS_W = 8;
    localparam int unsigned LOCK_LSB = 8;
    localparam int unsigned IDLE_OFF_STATE_SELECT_BIT = 10;
    localparam int unsigned RUN_OFF_STATE_SELECT_BIT = 11;
    localparam int unsigned BRAKE_ENABLE_BIT = 12;
    localparam int unsigned BRAKE_POLARITY_BIT = 13;
    localparam int unsigned AUTO_OUTPUT_ENABLE_BIT = 14;
    localparam int unsigned MAIN_OUTPUT_ENABLE_BIT = 15;

    localparam int unsigned CFG_FIELD_W = 5;
    localparam int unsigned OUTCTL_FIELD_W = 6;

    // ----------------------------------------------------------------
    // Dead-time timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned DT_CLK_PERIOD_NS = 10;
    localparam int unsigned DT_CLK_CYCLES = (DT_CLK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DT_SHIFT_MID = 1;
    localparam int unsigned DT_SHIFT_HI8 = 3;
    localparam int unsigned DT_SHIFT_HI16 = 4;

    typedef enum logic [1:0] {
        LOCK_OFF = 2'b00,
        LOCK_L1 = 2'b01,
        LOCK_L2 = 2'b10,
        LOCK_L3 = 2'b11
    } cdbc_lock_t;

    typedef enum logic [2:0] {
        OC_FROZEN = 3'b000,
        OC_ACT_MATCH = 3'b001,
        OC_INACT_MATCH = 3'b010,
        OC_TOGGLE = 3'b011,
        OC_FORCE_INACT = 3'b100,
        OC_FORCE_ACT = 3'b101,
        OC_PWM1 = 3'b110,
        OC_PWM2 = 3'b111
    } cdbc_oc_mode_t;

    typedef struct packed {
        logic input_mode;
        logic chan_preload_enable;
        cdbc_oc_mode_t output_compare_mode;
    } cdbc_chan_cfg_t;

    typedef struct packed {
        logic compl_idle_state;
        logic primary_idle_state;
        logic compl_output_polarity;
        logic chan_compl_output_enable;
        logic chan_output_polarity;
        logic chan_output_enable;
    } cdbc_chan_out_t;

    localparam cdbc_chan_cfg_t CFG_RESET = '0;
    localparam cdbc_chan_out_t OUTCTL_RESET = '0;

    function automatic logic [DT_W-1:0] cdbc_dead_time(input logic [7:0] dead_time_setting);
        logic [DT_W-1:0] steps;
        steps = '0;
        casez (dead_time_setting[7:5])
            3'b0??: steps = DT_W'(dead_time_setting);
            3'b10?: steps = DT_W'({1'b1, dead_time_setting[5:0]}) << DT_SHIFT_MID;
            3'b110: steps = DT_W'({1'b1, dead_time_setting[4:0]}) << DT_SHIFT_HI8;
            default: steps = DT_W'({1'b1, dead_time_setting[4:0]}) << DT_SHIFT_HI16;
        endcase
        return DT_W'(steps * DT_W'(DT_CLK_CYCLES));
    endfunction : cdbc_dead_time

endpackage : cdbc_pkg

// File: core/cdbc_compare_deadtime_brake.sv
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module cdbc_compare_deadtime_brake
    import cdbc_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [DATA_W-1:0] rdata_o,
    input wire logic [CMP_W-1:0] counter_value_i,
    input wire logic update_event_i,
    input wire logic [NUM_CHAN-1:0] capture_event_i,
    input wire logic brake_input_i,
    output logic [NUM_CHAN-1:0] primary_output_o,
    output logic [NUM_CHAN-1:0] primary_output_oe_o,
    output logic [NUM_CHAN-1:0] complementary_output_o,
    output logic [NUM_CHAN-1:0] complementary_output_oe_o,
    output logic main_output_enable_o
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [CMP_W-1:0] cmp_active_reg [NUM_CHAN];
    logic [CMP_W-1:0] cmp_shadow_reg [NUM_CHAN];
    cdbc_chan_cfg_t cfg_reg [NUM_CHAN];
    cdbc_chan_out_t outctl_reg [NUM_CHAN];
    logic [NUM_CHAN-1:0] p_out_reg;
    logic [NUM_CHAN-1:0] p_oe_reg;
    logic [NUM_CHAN-1:0] n_out_reg;
    logic [NUM_CHAN-1:0] n_oe_reg;
    logic [7:0] dead_time_setting_reg;
    cdbc_lock_t lock_level_reg;
    logic lock_written_reg;
    logic idle_off_state_select_reg;
    logic run_off_state_select_reg;
    logic brake_enable_reg;
    logic brake_polarity_reg;
    logic auto_output_enable_reg;
    logic main_output_enable_reg;
    logic brake_meta_reg;
    logic brake_sync_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic wr_bdt;
    logic wr_cfg;
    logic wr_outctl;
    logic brake_async;
    logic brake_sync_active;
    logic [DT_W-1:0] dead_time_len;
    logic [DATA_W-1:0] cfg_word;
    logic [DATA_W-1:0] outctl_word;
    logic [DATA_W-1:0] bdt_word;

    assign wr_bdt = wr_i && (addr_i == BDT_OFF);
    assign wr_cfg = wr_i && (addr_i == CHAN_CONFIG_OFF);
    assign wr_outctl = wr_i && (addr_i == CHAN_OUTCTL_OFF);
    assign dead_time_len = cdbc_dead_time(dead_time_setting_reg);

    // ----------------------------------------------------------------
    // Brake input
    // ----------------------------------------------------------------
    // Raw pin path bypasses the synchroniser on purpose: the brake
    // must drop main enable even when the clock has stopped.
    assign brake_async = brake_enable_reg & (brake_input_i == brake_polarity_reg);

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            brake_meta_reg <= 1'b0;
            brake_sync_reg <= 1'b0;
        end else begin
            brake_meta_reg <= brake_input_i;
            brake_sync_reg <= brake_meta_reg;
        end
    end

    // Polarity register feeds both paths, so a write acts one cycle later
    assign brake_sync_active = brake_enable_reg & (brake_sync_reg == brake_polarity_reg);

    always_ff @(posedge clk_i or posedge brake_async) begin
        if (brake_async) begin
            main_output_enable_reg <= 1'b0;
        end else if (!resetn_i) begin
            main_output_enable_reg <= 1'b0;
        end else if (wr_bdt) begin
            main_output_enable_reg <= wdata_i[MAIN_OUTPUT_ENABLE_BIT];
        end else if (update_event_i && auto_output_enable_reg && !brake_sync_active) begin
            main_output_enable_reg <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Brake and dead-time register with lock
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            lock_level_reg <= LOCK_OFF;
            lock_written_reg <= 1'b0;
        end else if (wr_bdt && !lock_written_reg) begin
            lock_level_reg <= cdbc_lock_t'(wdata_i[LOCK_LSB +: 2]);
            lock_written_reg <= 1'b1;
        end
    end

    // Protection uses the level in force before this write
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            dead_time_setting_reg <= DTS_RESET;
            brake_enable_reg <= 1'b0;
            brake_polarity_reg <= 1'b0;
            auto_output_enable_reg <= 1'b0;
        end else if (wr_bdt && lock_level_reg == LOCK_OFF) begin
            dead_time_setting_reg <= wdata_i[DTS_LSB +: DTS_W];
            brake_enable_reg <= wdata_i[BRAKE_ENABLE_BIT];
            brake_polarity_reg <= wdata_i[BRAKE_POLARITY_BIT];
            auto_output_enable_reg <= wdata_i[AUTO_OUTPUT_ENABLE_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            idle_off_state_select_reg <= 1'b0;
            run_off_state_select_reg <= 1'b0;
        end else if (wr_bdt && (lock_level_reg == LOCK_OFF || lock_level_reg == LOCK_L1)) begin
            idle_off_state_select_reg <= wdata_i[IDLE_OFF_STATE_SELECT_BIT];
            run_off_state_select_reg <= wdata_i[RUN_OFF_STATE_SELECT_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Per-channel compare, dead time and output stage
    // ----------------------------------------------------------------
    for (genvar i = 0; i < NUM_CHAN; i++) begin : g_chan
        localparam logic [ADDR_W-1:0] CMP_ADDR = ADDR_W'(CHAN1_CMP_OFF + CMP_STRIDE * i);
        cdbc_chan_cfg_t wr_cfg_val;
        cdbc_chan_out_t wr_out_val;
        logic wr_cmp;
        logic match;
        logic match_prev_reg;
        logic ref_reg;
        logic ref_next;
        logic en_prev_reg;
        logic moe_prev_reg;
        logic any_en;
        logic [DT_W-1:0] dt_cnt_reg;
        logic dt_busy;
        logic p_act;
        logic n_act;
        logic p_lvl;
        logic p_oe;
        logic n_lvl;
        logic n_oe;

        assign wr_cfg_val = cdbc_chan_cfg_t'(wdata_i[CFG_FIELD_W*i +: CFG_FIELD_W]);
        assign wr_out_val = cdbc_chan_out_t'(wdata_i[OUTCTL_FIELD_W*i +: OUTCTL_FIELD_W]);
        assign wr_cmp = wr_i && (addr_i == CMP_ADDR);

        always_ff @(posedge clk_i) begin
            if (!resetn_i) begin
                cfg_reg[i] <= CFG_RESET;
            end else if (wr_cfg) begin
                cfg_reg[i].input_mode <= wr_cfg_val.input_mode;
                if (lock_level_reg != LOCK_L3) begin
                    cfg_reg[i].chan_preload_enable <= wr_cfg_val.chan_preload_enable;
                    cfg_reg[i].output_compare_mode <= wr_cfg_val.output_compare_mode;
                end
            end
        end

        always_ff @(posedge clk_i) begin
            if (!resetn_i) begin
                outctl_reg[i] <= OUTCTL_RESET;
            end else if (wr_outctl) begin
                outctl_reg[i].chan_output_enable <= wr_out_val.chan_output_enable;
                outctl_reg[i].chan_compl_output_enable <= wr_out_val.chan_compl_output_enable;
                if (lock_level_reg == LOCK_OFF || lock_level_reg == LOCK_L1) begin
                    outctl_reg[i].chan_output_polarity <= wr_out_val.chan_output_polarity;
                    outctl_reg[i].compl_output_polarity <= wr_out_val.compl_output_polarity;
                end
                if (lock_level_reg == LOCK_OFF) begin
                    outctl_reg[i].primary_idle_state <= wr_out_val.primary_idle_state;
                    outctl_reg[i].compl_idle_state <= wr_out_val.compl_idle_state;
                end
            end
        end

        always_ff @(posedge clk_i) begin
            if (!resetn_i) begin
                cmp_active_reg[i] <= CMP_RESET;
                cmp_shadow_reg[i] <= CMP_RESET;
            end else if (cfg_reg[i].input_mode) begin
                if (capture_event_i[i] && outctl_reg[i].chan_output_enable) begin
                    cmp_active_reg[i] <= counter_value_i;
                end else if (wr_cmp) begin
                    cmp_active_reg[i] <= wdata_i[CMP_W-1:0];
                end
            end else begin
                if (wr_cmp) begin
                    cmp_shadow_reg[i] <= wdata_i[CMP_W-1:0];
                end
                if (wr_cmp && !cfg_reg[i].chan_preload_enable) begin
                    cmp_active_reg[i] <= wdata_i[CMP_W-1:0];
                end else if (update_event_i && cfg_reg[i].chan_preload_enable) begin
                    cmp_active_reg[i] <= cmp_shadow_reg[i];
                end
            end
        end

        // Match events fire once per arrival, not every cycle the counter holds
        assign match = (counter_value_i == cmp_active_reg[i]);

        always_comb begin
            ref_next = ref_reg;
            case (cfg_reg[i].output_compare_mode)
                OC_FROZEN: ref_next = ref_reg;
                OC_ACT_MATCH: ref_next = (match && !match_prev_reg) ? 1'b1 : ref_reg;
                OC_INACT_MATCH: ref_next = (match && !match_prev_reg) ? 1'b0 : ref_reg;
                OC_TOGGLE: ref_next = (match && !match_prev_reg) ? !ref_reg : ref_reg;
                OC_FORCE_INACT: ref_next = 1'b0;
                OC_FORCE_ACT: ref_next = 1'b1;
                OC_PWM1: ref_next = (counter_value_i < cmp_active_reg[i]);
                OC_PWM2: ref_next = !(counter_value_i < cmp_active_reg[i]);
                default: ref_next = ref_reg;
            endcase
            if (cfg_reg[i].input_mode) begin
                ref_next = 1'b0;
            end
        end

        assign any_en = outctl_reg[i].chan_output_enable | outctl_reg[i].chan_compl_output_enable;

        always_ff @(posedge clk_i) begin
            if (!resetn_i) begin
                match_prev_reg <= 1'b0;
                ref_reg <= 1'b0;
                en_prev_reg <= 1'b0;
                moe_prev_reg <= 1'b0;
            end else begin
                match_prev_reg <= match;
                ref_reg <= ref_next;
                en_prev_reg <= any_en;
                moe_prev_reg <= main_output_enable_reg;
            end
        end

        // Loads with the ref flip itself, so no zero dead-time cycle slips in
        always_ff @(posedge clk_i) begin
            if (!resetn_i) begin
                dt_cnt_reg <= '0;
            end else if ((ref_next != ref_reg) || (any_en && !en_prev_reg)
                         || (moe_prev_reg && !main_output_enable_reg)) begin
                dt_cnt_reg <= dead_time_len;
            end else if (dt_busy) begin
                dt_cnt_reg <= dt_cnt_reg - DT_W'(1);
            end
        end

        assign dt_busy = (dt_cnt_reg != '0) || (any_en && !en_prev_reg)
                         || (moe_prev_reg && !main_output_enable_reg);
        assign p_act = ref_reg & !dt_busy;
        assign n_act = !ref_reg & !dt_busy;

        always_comb begin
            if (main_output_enable_reg) begin
                if (outctl_reg[i].chan_output_enable) begin
                    p_lvl = p_act ^ outctl_reg[i].chan_output_polarity;
                    p_oe = 1'b1;
                end else begin
                    p_lvl = outctl_reg[i].chan_output_polarity;
                    p_oe = run_off_state_select_reg;
                end
                if (outctl_reg[i].chan_compl_output_enable) begin
                    n_lvl = n_act ^ outctl_reg[i].compl_output_polarity;
                    n_oe = 1'b1;
                end else begin
                    n_lvl = outctl_reg[i].compl_output_polarity;
                    n_oe = run_off_state_select_reg;
                end
            end else begin
                p_oe = idle_off_state_select_reg & any_en;
                n_oe = idle_off_state_select_reg & any_en;
                p_lvl = dt_busy ? outctl_reg[i].chan_output_polarity
                                : outctl_reg[i].primary_idle_state;
                n_lvl = dt_busy ? outctl_reg[i].compl_output_polarity
                                : outctl_reg[i].compl_idle_state;
            end
        end

        always_ff @(posedge clk_i) begin
            if (!resetn_i) begin
                p_out_reg[i] <= 1'b0;
                p_oe_reg[i] <= 1'b0;
                n_out_reg[i] <= 1'b0;
                n_oe_reg[i] <= 1'b0;
            end else begin
                p_out_reg[i] <= p_lvl;
                p_oe_reg[i] <= p_oe;
                n_out_reg[i] <= n_lvl;
                n_oe_reg[i] <= n_oe;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    always_comb begin
        cfg_word = '0;
        outctl_word = '0;
        for (int k = 0; k < NUM_CHAN; k++) begin
            cfg_word[CFG_FIELD_W*k +: CFG_FIELD_W] = cfg_reg[k];
            outctl_word[OUTCTL_FIELD_W*k +: OUTCTL_FIELD_W] = outctl_reg[k];
        end
    end

    assign bdt_word = {16'h0000, main_output_enable_reg, auto_output_enable_reg,
                       brake_polarity_reg, brake_enable_reg, run_off_state_select_reg,
                       idle_off_state_select_reg, lock_level_reg, dead_time_setting_reg};

    // Compare reads always show the active value, never the shadow
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rdata_reg <= '0;
        end else if (rd_i) begin
            case (addr_i)
                CHAN1_CMP_OFF: rdata_reg <= DATA_W'(cmp_active_reg[0]);
                CHAN2_CMP_OFF: rdata_reg <= DATA_W'(cmp_active_reg[1]);
                CHAN3_CMP_OFF: rdata_reg <= DATA_W'(cmp_active_reg[2]);
                CHAN4_CMP_OFF: rdata_reg <= DATA_W'(cmp_active_reg[3]);
                BDT_OFF: rdata_reg <= bdt_word;
                CHAN_CONFIG_OFF: rdata_reg <= cfg_word;
                CHAN_OUTCTL_OFF: rdata_reg <= outctl_word;
                default: rdata_reg <= '0;
            endcase
        end else begin
            rdata_reg <= '0;
        end
    end

    assign rdata_o = rdata_reg;
    assign primary_output_o = p_out_reg;
    assign primary_output_oe_o = p_oe_reg;
    assign complementary_output_o = n_out_reg;
    assign complementary_output_oe_o = n_oe_reg;
    assign main_output_enable_o = main_output_enable_reg;

endmodule : cdbc_compare_deadtime_brake

`default_nettype wire

// File: sim/cdbc_props.sv
`timescale 1ns/1ps
`default_nettype none
module cdbc_props
    import cdbc_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [DATA_W-1:0] rdata_o,
    input wire logic update_event_i,
    input wire logic brake_input_i,
    input wire logic [NUM_CHAN-1:0] primary_output_oe_o,
    input wire logic main_output_enable_o
);
    // ------------------------------------------------------------
    // First brake/dead-time word, valid once the lock took hold
    // ------------------------------------------------------------
    logic seen_reg;
    logic arm_reg;
    logic [15:0] cfg_reg;
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            seen_reg <= 1'b0;
            cfg_reg <= 16'h0000;
        end else if (wr_i && addr_i == BDT_OFF && !seen_reg) begin
            seen_reg <= 1'b1;
            cfg_reg <= wdata_i[15:0];
        end
    end
    // One extra cycle: new brake polarity is not yet in force
    always_ff @(posedge clk_i) begin
        arm_reg <= resetn_i && seen_reg;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    property p_rd_idle; !$past(rd_i) |-> rdata_o == '0; endproperty
    property p_rd_upper; rd_i |=> rdata_o[31:16] == 16'h0000; endproperty
    property p_mo_rise;
        $rose(main_output_enable_o) |-> $past(wr_i) || $past(update_event_i);
    endproperty
    property p_reset;
        disable iff (1'b0) !resetn_i |=> !main_output_enable_o && primary_output_oe_o == '0;
    endproperty
    property p_brake;
        arm_reg && cfg_reg[9:8] != 2'b00 && cfg_reg[BRAKE_ENABLE_BIT]
            && brake_input_i == cfg_reg[BRAKE_POLARITY_BIT]
            |-> !main_output_enable_o;
    endproperty
    property p_brk_off;
        seen_reg && !cfg_reg[BRAKE_ENABLE_BIT] && wr_i && addr_i == BDT_OFF && wdata_i[MAIN_OUTPUT_ENABLE_BIT]
            |=> main_output_enable_o;
    endproperty
    property p_lock_once;
        seen_reg && rd_i && addr_i == BDT_OFF |=> rdata_o[9:8] == cfg_reg[9:8];
    endproperty
    property p_lock_dts;
        seen_reg && cfg_reg[9:8] != 2'b00 && rd_i && addr_i == BDT_OFF
            |=> rdata_o[7:0] == cfg_reg[7:0];
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
    a_mo_rise: assert property (p_mo_rise) else $error("main enable rose alone");
    a_reset: assert property (p_reset) else $error("outputs live in reset");
    a_brake: assert property (p_brake) else $error("brake left main on");
    a_brk_off: assert property (p_brk_off) else $error("disabled brake acted");
    a_lock_once: assert property (p_lock_once) else $error("lock level rewritten");
    a_lock_dts: assert property (p_lock_dts) else $error("locked dead time changed");
    c_brake: cover property (arm_reg && cfg_reg[BRAKE_ENABLE_BIT] && brake_input_i);
    c_auto: cover property ($rose(main_output_enable_o) && $past(update_event_i));
    c_rd: cover property (rd_i && addr_i == BDT_OFF);
endmodule : cdbc_props
bind cdbc_compare_deadtime_brake cdbc_props u_cdbc_props (.clk_i(clk_i),
    .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .update_event_i(update_event_i),
    .brake_input_i(brake_input_i), .primary_output_oe_o(primary_output_oe_o),
    .main_output_enable_o(main_output_enable_o));
`default_nettype wire

// File: sim/cdbc_power_stage_model.sv
`timescale 1ns/1ps
`default_nettype none
module cdbc_power_stage_model (
    input wire logic brake_req_i,
    input wire logic [3:0] pri_i,
    input wire logic [3:0] pri_oe_i,
    input wire logic [3:0] cmp_i,
    input wire logic [3:0] cmp_oe_i,
    output logic brake_input_o,
    output logic [3:0] high_side_o,
    output logic [3:0] low_side_o
);
    // Fault source asserts high; idle level is the inverse
    assign brake_input_o = brake_req_i;
    // Gate driver inputs have pull-downs when left undriven
    assign high_side_o = pri_i & pri_oe_i;
    assign low_side_o = cmp_i & cmp_oe_i;
endmodule : cdbc_power_stage_model
`default_nettype wire

// File: sim/compare_deadtime_brake_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fail_count++; \
    $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end
module compare_deadtime_brake_ctrl_tb;
    import cdbc_pkg::*;
    logic clk_i = 1'b0, resetn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, rd_d = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0, rdata_o, exp_w;
    logic [15:0] counter_value_i = 16'h0, cmp, cap;
    logic update_event_i = 1'b0, brake_req = 1'b0, brake_input_i, main_output_enable_o;
    logic [3:0] capture_event_i = 4'h0, po, poe, co, coe, hs, ls;
    logic [7:0] dts_list [4] = '{8'h05, 8'h81, 8'hc1, 8'he0};
    logic [31:0] exp_q [$];
    int fail_count = 0, total_checks = 0, cyc = 0, n;
    always #5 clk_i = ~clk_i;
    cdbc_compare_deadtime_brake u_cdbc_compare_deadtime_brake (.clk_i(clk_i),
        .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .counter_value_i(counter_value_i), .update_event_i(update_event_i),
        .capture_event_i(capture_event_i), .brake_input_i(brake_input_i),
        .primary_output_o(po), .primary_output_oe_o(poe), .complementary_output_o(co),
        .complementary_output_oe_o(coe), .main_output_enable_o(main_output_enable_o));
    cdbc_power_stage_model u_cdbc_power_stage_model (.brake_req_i(brake_req), .pri_i(po),
        .pri_oe_i(poe), .cmp_i(co), .cmp_oe_i(coe), .brake_input_o(brake_input_i),
        .high_side_o(hs), .low_side_o(ls));
    // ------------------------------------------------------------
    // Read scoreboard and watchdog
    // ------------------------------------------------------------
    always @(posedge clk_i) begin
        rd_d <= rd_i;
        if (rd_d) begin
            exp_w = exp_q.pop_front();
            `CHK("rdata", exp_w, rdata_o)
        end
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        addr_i <= a; wdata_i <= d; wr_i <= 1'b1; @(posedge clk_i);
        wr_i <= 1'b0; @(posedge clk_i);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e); addr_i <= a; rd_i <= 1'b1; @(posedge clk_i);
        rd_i <= 1'b0; @(posedge clk_i);
    endtask : rd
    task automatic pulse_update();
        update_event_i <= 1'b1; @(posedge clk_i);
        update_event_i <= 1'b0; @(posedge clk_i);
    endtask : pulse_update
    task automatic do_reset();
        resetn_i <= 1'b0; repeat (8) @(posedge clk_i);
        resetn_i <= 1'b1; @(posedge clk_i);
    endtask : do_reset
    function automatic int dt_of(input logic [7:0] d);
        if (!d[7]) return int'(d);
        if (!d[6]) return (64 + int'(d[5:0])) * 2;
        if (!d[5]) return (32 + int'(d[4:0])) * 8;
        return (32 + int'(d[4:0])) * 16;
    endfunction : dt_of
    initial begin
        void'($urandom(32'hc98c));
        do_reset();
        for (int i = 0; i < 5; i++) rd(8'h34 + 8'(4 * i), 32'h0);
        rd(8'h48, 32'h0);
        wr(CHAN_CONFIG_OFF, 32'h0000_41c6);
        wr(CHAN_OUTCTL_OFF, 32'h0000_1005);
        cmp = 16'h0100 | 16'($urandom_range(0, 255));
        wr(CHAN1_CMP_OFF, {16'h0, cmp});
        rd(CHAN1_CMP_OFF, {16'h0, cmp});
        wr(BDT_OFF, 32'h0000_a800);
        brake_req <= 1'b1; repeat (4) @(posedge clk_i);
        rd(BDT_OFF, 32'h0000_a800);
        brake_req <= 1'b0;
        foreach (dts_list[i]) begin
            wr(BDT_OFF, {16'h0, 8'h89, dts_list[i]});
            rd(BDT_OFF, {16'h0, 8'h88, dts_list[i]});
            counter_value_i <= 16'h0;
            n = 0;
            while (hs[0] !== 1'b1 && n < 700) begin @(posedge clk_i); n++; end
            counter_value_i <= cmp;
            n = 0;
            do begin @(posedge clk_i); #1; n++; end while (ls[0] !== 1'b1 && n < 700);
            `CHK("dead time", dt_of(dts_list[i]) + 2, n)
        end
        wr(CHAN_OUTCTL_OFF, 32'h0000_1007);
        repeat (3) @(posedge clk_i);
        `CHK("inactive level", 1'b1, po[0])
        wr(CHAN2_CMP_OFF, 32'h0000_1234);
        rd(CHAN2_CMP_OFF, 32'h0);
        pulse_update();
        rd(CHAN2_CMP_OFF, 32'h0000_1234);
        cap = 16'($urandom());
        counter_value_i <= cap; @(posedge clk_i);
        capture_event_i <= 4'b0100; @(posedge clk_i);
        capture_event_i <= 4'b0000; @(posedge clk_i);
        rd(CHAN3_CMP_OFF, {16'h0, cap});
        $display("test compare and dead time done");
        do_reset();
        wr(CHAN_OUTCTL_OFF, 32'h0000_0005);
        wr(BDT_OFF, 32'h0000_7110);
        wr(BDT_OFF, 32'h0000_f122);
        rd(BDT_OFF, 32'h0000_f110);
        brake_req <= 1'b1; repeat (2) @(posedge clk_i);
        rd(BDT_OFF, 32'h0000_7110);
        `CHK("drive enable", 1'b0, poe[0])
        pulse_update();
        rd(BDT_OFF, 32'h0000_7110);
        brake_req <= 1'b0; repeat (4) @(posedge clk_i);
        pulse_update();
        rd(BDT_OFF, 32'h0000_f110);
        $display("test brake and lock done");
        finish_test();
    end
endmodule : compare_deadtime_brake_ctrl_tb
`default_nettype wire
